/* File: core/axs_stop_status.v */
// axis stop handling, motion status flags and compare range
`timescale 1ns/1ns
`default_nettype none
`include "axs_stop_regs.vh"

module axs_stop_status (
    input wire clk_sys,
    input wire nrst,
    input wire cmdValid,
    input wire [7:0] cmdCode,
    input wire startValid,
    input wire startDirMinus,
    input wire startFixed,
    input wire [1:0] startCurve,
    input wire [27:0] startPulses,
    input wire [15:0] initSpeed,
    input wire [15:0] driveSpeed,
    input wire [15:0] interruptStopModeReg,
    input wire [15:0] limitModeReg,
    input wire eventStatusRead,
    input wire [31:0] positionCount,
    input wire [31:0] compUpper,
    input wire [31:0] compLower,
    input wire [1:0] hardwareLimitInputsN,
    input wire [2:0] externalStopInputsN,
    input wire emergencyStopInputN,
    input wire alarmInputN,
    output reg drivePulse,
    output reg driveDirMinus,
    output reg [15:0] mainStatusReg,
    output reg [15:0] motionStatusReg,
    output reg [15:0] eventStatusReg,
    output reg interruptOut,
    output reg compUpperGe,
    output reg compLowerLt
);

    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_ACCEL = 3'h1;
    localparam [2:0] ST_CONST = 3'h2;
    localparam [2:0] ST_DECEL = 3'h3;
    localparam [2:0] ST_NEAR = 3'h4;
    localparam [2:0] ST_RUNON = 3'h5;
    localparam integer RAMP_CYC = `AXS_RAMP_CYCLES;
    // tick count stays below 1024, so the upper bits are dropped on purpose
    localparam [9:0] RAMP_LAST = RAMP_CYC[9:0] - 10'h001;
    localparam integer NPIN = 7;

    // compare on bits 30:0 only; bit 31 is ignored by design
    function cmpGe31;
        input [31:0] a;
        input [31:0] b;
        begin
            cmpGe31 = ($signed(a[30:0]) >= $signed(b[30:0]));
        end
    endfunction

    reg [2:0] state;
    reg [15:0] speed;
    reg [27:0] remaining;
    reg [27:0] accelPulses;
    reg fixedDrive;
    reg [1:0] curve;
    reg stopPending;
    reg [9:0] tickCnt;
    reg constEndHit;
    reg [NPIN-1:0] pinSyncA;
    reg [NPIN-1:0] pinSyncB;
    reg next_event;

    wire pulseTick;
    wire running;
    wire rampTick;
    wire [NPIN-1:0] pinRaw;
    wire [1:0] limitOn;
    wire [2:0] stopOn;
    wire emergencyOn;
    wire alarmOn;
    wire limitAhead;
    wire softAhead;
    wire stopHit;
    wire suddenCause;
    wire decelCause;
    wire fixedDone;
    wire [16:0] speedUp;
    wire [16:0] tailTop;
    wire atTop;
    wire atInit;
    wire inTail;
    wire needDecel;

    assign pinRaw = {alarmInputN, emergencyStopInputN, externalStopInputsN, hardwareLimitInputsN};

    // two-stage synchronisers for every pin input
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
            always @(posedge clk_sys) begin
                if (!nrst) begin
                    pinSyncA[gi] <= 1'b1;
                    pinSyncB[gi] <= 1'b1;
                end else begin
                    pinSyncA[gi] <= pinRaw[gi];
                    pinSyncB[gi] <= pinSyncA[gi];
                end
            end
        end
    endgenerate

    assign limitOn = ~pinSyncB[1:0];
    assign stopOn = ~pinSyncB[4:2];
    assign emergencyOn = ~pinSyncB[5];
    assign alarmOn = ~pinSyncB[6];

    assign running = (state != ST_IDLE);
    assign rampTick = (tickCnt == RAMP_LAST);
    assign limitAhead = driveDirMinus ? limitOn[1] : limitOn[0];

    assign softAhead = driveDirMinus ? (limitModeReg[`AXS_LMR_SOFT_MINUS_EN] & compLowerLt)
                                     : (limitModeReg[`AXS_LMR_SOFT_PLUS_EN] & compUpperGe);

    assign stopHit = |(stopOn & {interruptStopModeReg[`AXS_IMR_STOP2_EN],
                                 interruptStopModeReg[`AXS_IMR_STOP1_EN],
                                 interruptStopModeReg[`AXS_IMR_STOP0_EN]});

    assign suddenCause = (cmdValid & (cmdCode == `AXS_CMD_SUDDEN_STOP)) | emergencyOn | alarmOn |
                         (limitAhead & ~limitModeReg[`AXS_LMR_LIMIT_DECEL]);

    assign decelCause = (cmdValid & (cmdCode == `AXS_CMD_DECEL_STOP)) |
                        (limitAhead & limitModeReg[`AXS_LMR_LIMIT_DECEL]) | softAhead | stopHit;

    assign fixedDone = fixedDrive & pulseTick & (remaining == 28'h0000001);
    assign speedUp = {1'b0, speed} + 17'h00001;
    assign tailTop = {1'b0, initSpeed} + {1'b0, `AXS_SCURVE_TAIL};
    assign atTop = (speedUp >= {1'b0, driveSpeed});
    assign atInit = (speed <= initSpeed);
    assign inTail = ({1'b0, speed} <= tailTop);
    assign needDecel = decelCause | stopPending | (fixedDrive & (remaining <= accelPulses));

    axs_pulse_gen u_pulse (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .run(running),
        .speed(speed),
        .pulse(pulseTick)
    );

    always @(posedge clk_sys) begin
        if (!nrst) begin
            compUpperGe <= 1'b0;
            compLowerLt <= 1'b0;
        end else begin
            compUpperGe <= cmpGe31(positionCount, compUpper);
            compLowerLt <= ~cmpGe31(positionCount, compLower);
        end
    end

    always @(posedge clk_sys) begin
        if (!nrst) begin
            tickCnt <= 10'h000;
        end else if (!running || rampTick) begin
            tickCnt <= 10'h000;
        end else begin
            tickCnt <= tickCnt + 10'h001;
        end
    end

    // drive sequencer
    always @(posedge clk_sys) begin
        if (!nrst) begin
            state <= ST_IDLE;
            speed <= `AXS_SPEED_RESET;
            remaining <= 28'h0000000;
            accelPulses <= 28'h0000000;
            fixedDrive <= 1'b0;
            curve <= `AXS_CURVE_CONST;
            stopPending <= 1'b0;
            driveDirMinus <= 1'b0;
            constEndHit <= 1'b0;
        end else begin
            constEndHit <= 1'b0;
            if (running && fixedDrive && pulseTick) begin
                remaining <= remaining - 28'h0000001;
            end
            if (state == ST_IDLE) begin
                stopPending <= 1'b0;
                if (startValid && !(startFixed && startPulses == 28'h0000000)) begin
                    driveDirMinus <= startDirMinus;
                    fixedDrive <= startFixed;
                    curve <= startCurve;
                    remaining <= startPulses;
                    accelPulses <= 28'h0000000;
                    if (startCurve == `AXS_CURVE_CONST) begin
                        speed <= driveSpeed;
                        state <= ST_CONST;
                    end else begin
                        speed <= initSpeed;
                        state <= ST_ACCEL;
                    end
                end
            end else if (suddenCause) begin
                state <= ST_IDLE;
                if (state == ST_CONST || state == ST_NEAR) begin
                    constEndHit <= 1'b1;
                end
            end else if (fixedDone && state != ST_RUNON) begin
                state <= ST_IDLE;
                if (state == ST_CONST || state == ST_NEAR) begin
                    constEndHit <= 1'b1;
                end
            end else begin
                if (decelCause) begin
                    stopPending <= 1'b1;
                end
                case (state)
                    ST_ACCEL: begin
                        if (pulseTick) begin
                            accelPulses <= accelPulses + 28'h0000001;
                        end
                        if (needDecel) begin
                            state <= ST_DECEL;
                        end else if (rampTick) begin
                            if (atTop) begin
                                speed <= driveSpeed;
                                state <= ST_CONST;
                            end else begin
                                speed <= speedUp[15:0];
                            end
                        end
                    end
                    ST_CONST: begin
                        if (curve == `AXS_CURVE_CONST) begin
                            if (decelCause) begin
                                state <= ST_IDLE;
                                constEndHit <= 1'b1;
                            end
                        end else if (needDecel) begin
                            state <= ST_DECEL;
                            constEndHit <= 1'b1;
                        end
                    end
                    ST_DECEL: begin
                        // S-curve tail holds speed for a fixed drive; otherwise it keeps slowing down to init speed
                        if (curve == `AXS_CURVE_SCURVE && inTail) begin
                            state <= ST_NEAR;
                        end else if (atInit) begin
                            speed <= initSpeed;
                            if (!fixedDrive) begin
                                state <= ST_IDLE;
                            end
                        end else if (rampTick) begin
                            speed <= speed - 16'h0001;
                        end
                    end
                    ST_NEAR: begin
                        // decel request here runs on, fixed S-curve only
                        if (fixedDrive && decelCause) begin
                            state <= ST_RUNON;
                            constEndHit <= 1'b1;
                        end else if (!fixedDrive) begin
                            if (atInit) begin
                                state <= ST_IDLE;
                                constEndHit <= 1'b1;
                            end else if (rampTick) begin
                                speed <= speed - 16'h0001;
                            end
                        end
                    end
                    ST_RUNON: begin
                        // pulses continue until a sudden cause arrives
                        state <= ST_RUNON;
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // status registers and pulse output
    always @(posedge clk_sys) begin
        if (!nrst) begin
            drivePulse <= 1'b0;
            mainStatusReg <= `AXS_STATUS_RESET;
            motionStatusReg <= `AXS_STATUS_RESET;
        end else begin
            drivePulse <= pulseTick;
            mainStatusReg <= `AXS_STATUS_RESET;
            mainStatusReg[`AXS_MAIN_DRIVE] <= running;
            motionStatusReg <= `AXS_STATUS_RESET;
            motionStatusReg[`AXS_MSR_ACCEL] <= (state == ST_ACCEL);
            motionStatusReg[`AXS_MSR_CONST] <= (state == ST_CONST) || (state == ST_NEAR);
            motionStatusReg[`AXS_MSR_DECEL] <= (state == ST_DECEL);
            motionStatusReg[`AXS_MSR_LIMIT_PLUS] <= limitOn[0];
            motionStatusReg[`AXS_MSR_LIMIT_MINUS] <= limitOn[1];
        end
    end

    // set wins over the clear by read, so no event is lost
    always @* begin
        next_event = constEndHit | (eventStatusReg[`AXS_EVT_CEND] & ~eventStatusRead);
    end

    always @(posedge clk_sys) begin
        if (!nrst) begin
            eventStatusReg <= `AXS_STATUS_RESET;
            interruptOut <= 1'b0;
        end else begin
            eventStatusReg <= `AXS_STATUS_RESET;
            eventStatusReg[`AXS_EVT_CEND] <= next_event;
            interruptOut <= next_event & interruptStopModeReg[`AXS_IMR_CEND_EN];
        end
    end

endmodule

`default_nettype wire

/* File: pkg/axs_stop_regs.vh */
// constants for the axis stop and motion status block
`ifndef AXS_STOP_REGS_VH
`define AXS_STOP_REGS_VH

// command codes
`define AXS_CMD_DECEL_STOP 8'h26
`define AXS_CMD_SUDDEN_STOP 8'h27

// interrupt/stop mode register fields
`define AXS_IMR_STOP0_EN 1
`define AXS_IMR_STOP1_EN 3
`define AXS_IMR_STOP2_EN 5
`define AXS_IMR_CEND_EN 13

// limit mode register fields
`define AXS_LMR_SOFT_PLUS_EN 0
`define AXS_LMR_SOFT_MINUS_EN 1
`define AXS_LMR_LIMIT_DECEL 2

// motion status register fields
`define AXS_MSR_ACCEL 2
`define AXS_MSR_CONST 3
`define AXS_MSR_DECEL 4
`define AXS_MSR_LIMIT_PLUS 12
`define AXS_MSR_LIMIT_MINUS 13

// main status and event status fields
`define AXS_MAIN_DRIVE 0
`define AXS_EVT_CEND 5

// reset values
`define AXS_STATUS_RESET 16'h0000
`define AXS_SPEED_RESET 16'h0000

// curve kinds
`define AXS_CURVE_CONST 2'h0
`define AXS_CURVE_LINEAR 2'h1
`define AXS_CURVE_SCURVE 2'h2

// timing: speed changes by one step per ramp tick
`define AXS_CLK_PERIOD_NS 10
`define AXS_RAMP_TICK_NS 10000
`define AXS_RAMP_CYCLES (`AXS_RAMP_TICK_NS / `AXS_CLK_PERIOD_NS)

// width of the near-stop speed band above initial speed
`define AXS_SCURVE_TAIL 16'h0004

`endif

/* File: core/axs_pulse_gen.v */
// phase accumulator that turns a speed word into drive pulses
`timescale 1ns/1ns
`default_nettype none

module axs_pulse_gen (
    input wire clk_sys,
    input wire nrst,
    input wire run,
    input wire [15:0] speed,
    output reg pulse
);

    reg [15:0] acc;
    wire [16:0] sum;

    assign sum = {1'b0, acc} + {1'b0, speed};

    // pulse rate is speed/65536 of the clock; carry marks one pulse
    always @(posedge clk_sys) begin
        if (!nrst) begin
            acc <= 16'h0000;
            pulse <= 1'b0;
        end else if (run) begin
            acc <= sum[15:0];
            pulse <= sum[16];
        end else begin
            acc <= 16'h0000;
            pulse <= 1'b0;
        end
    end

endmodule

`default_nettype wire

/* File: bench/axs_motor_model.sv */
// motor driver model: follows drive pulses and tracks shaft position
`timescale 1ns/1ns
`default_nettype none
module axs_motor_model (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic stepPulse,
    input wire logic stepDirMinus,
    output logic [31:0] shaftPos,
    output int stepCount
);
    // position also feeds the block's position counter, so compares see real travel
    always @(posedge clk_sys) begin
        if (!nrst) begin
            shaftPos <= 32'h0;
            stepCount <= 0;
        end else if (stepPulse) begin
            shaftPos <= stepDirMinus ? shaftPos - 32'h1 : shaftPos + 32'h1;
            stepCount <= stepCount + 1;
        end
    end
endmodule
`default_nettype wire

/* File: bench/axs_stop_monitor.sv */
// assertion checker for the axis stop and status block
`timescale 1ns/1ns
`default_nettype none
`include "axs_stop_regs.vh"
module axs_stop_monitor (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic cmdValid,
    input wire logic [7:0] cmdCode,
    input wire logic [15:0] interruptStopModeReg,
    input wire logic [15:0] limitModeReg,
    input wire logic eventStatusRead,
    input wire logic [31:0] positionCount,
    input wire logic [31:0] compUpper,
    input wire logic [1:0] hardwareLimitInputsN,
    input wire logic emergencyStopInputN,
    input wire logic driveDirMinus,
    input wire logic [15:0] mainStatusReg,
    input wire logic [15:0] motionStatusReg,
    input wire logic [15:0] eventStatusReg,
    input wire logic interruptOut,
    input wire logic compUpperGe
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    wire logic geNow = $signed(positionCount[30:0]) >= $signed(compUpper[30:0]);
    wire logic drv = mainStatusReg[`AXS_MAIN_DRIVE];
    wire logic evt = eventStatusReg[`AXS_EVT_CEND];

    AST_CMP_RANGE: assert property ($past(nrst) |-> compUpperGe == $past(geNow))
        else $error("upper compare wrong");
    AST_SUDDEN: assert property (cmdValid && cmdCode == `AXS_CMD_SUDDEN_STOP && drv |-> ##[1:3] !drv)
        else $error("sudden stop slow");
    AST_HW_SUDDEN: assert property (drv && !driveDirMinus && !hardwareLimitInputsN[0] && !limitModeReg[2]
        |-> ##[1:6] !drv) else $error("limit stop slow");
    AST_FLAGS: assert property ($onehot0(motionStatusReg[4:2]))
        else $error("motion flags clash");
    AST_EMG: assert property (!emergencyStopInputN && drv |-> ##[1:6] !drv)
        else $error("emergency stop slow");
    AST_INT_RISE: assert property ($rose(evt) && interruptStopModeReg[13] |-> interruptOut)
        else $error("interrupt missing");
    AST_LIM_STATUS: assert property ((!hardwareLimitInputsN[0]) [*5] |-> motionStatusReg[12])
        else $error("plus limit status missing");
    AST_INT_GATE: assert property (interruptOut |-> evt)
        else $error("interrupt without event");
    AST_EV_HOLD: assert property (evt && !eventStatusRead |=> evt)
        else $error("event lost");
    AST_EV_CLR: assert property (eventStatusRead && !drv && !$past(drv) && !$past(drv, 2) |=> !evt)
        else $error("event not cleared");
    cover property (cmdValid && cmdCode == `AXS_CMD_DECEL_STOP && drv);
    cover property ($rose(interruptOut));
    cover property ($fell(drv) && motionStatusReg[12]);
endmodule
bind axs_stop_status axs_stop_monitor mon_u (.clk_sys(clk_sys), .nrst(nrst), .cmdValid(cmdValid),
    .cmdCode(cmdCode), .interruptStopModeReg(interruptStopModeReg), .limitModeReg(limitModeReg),
    .eventStatusRead(eventStatusRead), .positionCount(positionCount), .compUpper(compUpper),
    .hardwareLimitInputsN(hardwareLimitInputsN), .emergencyStopInputN(emergencyStopInputN),
    .driveDirMinus(driveDirMinus), .mainStatusReg(mainStatusReg), .motionStatusReg(motionStatusReg),
    .eventStatusReg(eventStatusReg), .interruptOut(interruptOut), .compUpperGe(compUpperGe));
`default_nettype wire

/* File: bench/tb.sv */
// self-checking bench: drives, stop causes, status flags and compare range
`timescale 1ns/1ns
`default_nettype none
`include "axs_stop_regs.vh"
module tb;
    logic clk_sys, nrst, cmdValid, startValid, dirM, fixd, evRd, emergency_stop_input, almN, pulse, dirOut, intOut, geU, ltL;
    logic [1:0] curve, limN;
    logic [2:0] stopN;
    logic [7:0] cmdCode;
    logic [15:0] initSp, drvSp, imr, lmr, mainSt, motSt, evtSt;
    logic [27:0] pulses;
    logic [31:0] pos, cmpU, cmpL, p0;
    int numErrors = 0, samplesChecked = 0, cyc = 0, cnt, n0;

    axs_stop_status dut_u (.clk_sys(clk_sys), .nrst(nrst), .cmdValid(cmdValid), .cmdCode(cmdCode),
        .startValid(startValid), .startDirMinus(dirM), .startFixed(fixd), .startCurve(curve),
        .startPulses(pulses), .initSpeed(initSp), .driveSpeed(drvSp), .interruptStopModeReg(imr),
        .limitModeReg(lmr), .eventStatusRead(evRd), .positionCount(pos), .compUpper(cmpU),
        .compLower(cmpL), .hardwareLimitInputsN(limN), .externalStopInputsN(stopN),
        .emergencyStopInputN(emergency_stop_input), .alarmInputN(almN), .drivePulse(pulse), .driveDirMinus(dirOut),
        .mainStatusReg(mainSt), .motionStatusReg(motSt), .eventStatusReg(evtSt),
        .interruptOut(intOut), .compUpperGe(geU), .compLowerLt(ltL));
    axs_motor_model motor_u (.clk_sys(clk_sys), .nrst(nrst), .stepPulse(pulse), .stepDirMinus(dirOut),
        .shaftPos(pos), .stepCount(cnt));

    initial begin
        clk_sys = 0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic endSim;
        $display("checks %0d errors %0d", samplesChecked, numErrors);
        if (numErrors == 0 && samplesChecked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // a hung drive must still reach the verdict
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            numErrors++;
            endSim;
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samplesChecked++;
        if (got !== exp) begin
            numErrors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // flag is up one edge after the start edge, so check it two edges after that edge
    task automatic go(input logic f, input logic [1:0] c, input logic [27:0] n);
        @(negedge clk_sys);
        fixd = f;
        curve = c;
        pulses = n;
        startValid = 1;
        @(negedge clk_sys);
        startValid = 0;
        repeat (2) @(negedge clk_sys);
    endtask

    task automatic cmd(input logic [7:0] c);
        @(negedge clk_sys);
        cmdCode = c;
        cmdValid = 1;
        @(negedge clk_sys);
        cmdValid = 0;
    endtask

    task automatic waitIdle(input int lim);
        int k;
        k = 0;
        while (mainSt[`AXS_MAIN_DRIVE] !== 1'b0 && k < lim) begin
            @(negedge clk_sys);
            k++;
        end
        chk("drive flag idle", 0, mainSt[`AXS_MAIN_DRIVE]);
    endtask

    task automatic clrEv;
        @(negedge clk_sys);
        evRd = 1;
        @(negedge clk_sys);
        evRd = 0;
        chk("event cleared", 0, {evtSt[`AXS_EVT_CEND], intOut});
    endtask

    initial begin
        {nrst, cmdValid, startValid, dirM, fixd, evRd} = '0;
        {emergency_stop_input, almN, limN, stopN} = '1;
        cmdCode = 8'h00;
        curve = 2'h0;
        pulses = 28'h0;
        initSp = 16'h0800;
        drvSp = 16'h0800;
        imr = 16'h202a;
        lmr = 16'h0000;
        cmpU = 32'h3fff_ffff;
        cmpL = 32'hc000_0000;
        repeat (3) @(negedge clk_sys);
        nrst = 1;
        chk("status after reset", 0, {mainSt, motSt});
        chk("event after reset", 0, {evtSt, intOut});
        for (int e = 1; e >= 0; e--) begin
            imr[13] = e[0];
            n0 = cnt;
            go(1, `AXS_CURVE_CONST, 28'd20);
            chk("drive flag", 1, mainSt[`AXS_MAIN_DRIVE]);
            chk("constant flags", 3'h2, motSt[4:2]);
            waitIdle(1000);
            repeat (3) @(negedge clk_sys);
            chk("fixed pulse count", 20, cnt - n0);
            chk("end event", 1, evtSt[`AXS_EVT_CEND]);
            chk("interrupt gate", e, intOut);
            clrEv;
        end
        imr[13] = 1;
        drvSp = 16'h0803;
        go(0, `AXS_CURVE_LINEAR, 28'd0);
        chk("accel flags", 3'h1, motSt[4:2]);
        repeat (4000) @(negedge clk_sys);
        chk("cruise flags", 3'h2, motSt[4:2]);
        cmd(`AXS_CMD_DECEL_STOP);
        repeat (3) @(negedge clk_sys);
        chk("decel flags", 3'h4, motSt[4:2]);
        waitIdle(4000);
        repeat (3) @(negedge clk_sys);
        chk("cruise end event", 1, evtSt[`AXS_EVT_CEND]);
        clrEv;
        // fixed S-curve: decel request in the near-stop band runs on until a sudden stop
        go(1, `AXS_CURVE_SCURVE, 28'd200);
        repeat (4500) @(negedge clk_sys);
        chk("near-stop flags", 3'h2, motSt[4:2]);
        cmd(`AXS_CMD_DECEL_STOP);
        repeat (100) @(negedge clk_sys);
        chk("run-on flags", 3'h0, motSt[4:2]);
        chk("run-on drive flag", 1, mainSt[`AXS_MAIN_DRIVE]);
        chk("run-on event", 1, evtSt[`AXS_EVT_CEND]);
        cmd(`AXS_CMD_SUDDEN_STOP);
        waitIdle(10);
        clrEv;
        lmr = 16'h0004;
        go(0, `AXS_CURVE_LINEAR, 28'd0);
        repeat (4000) @(negedge clk_sys);
        limN[0] = 0;
        repeat (5) @(negedge clk_sys);
        chk("limit decel flags", 3'h4, motSt[4:2]);
        chk("plus limit status", 1, motSt[12]);
        waitIdle(4000);
        limN[0] = 1;
        lmr = 16'h0000;
        drvSp = 16'h0800;
        imr = 16'h2028;
        stopN = 3'h6;
        go(0, `AXS_CURVE_CONST, 28'd0);
        repeat (10) @(negedge clk_sys);
        chk("masked stop input", 1, mainSt[`AXS_MAIN_DRIVE]);
        cmd(`AXS_CMD_SUDDEN_STOP);
        repeat (2) @(negedge clk_sys);
        chk("sudden stop", 0, mainSt[`AXS_MAIN_DRIVE]);
        repeat (4) @(negedge clk_sys);
        n0 = cnt;
        repeat (40) @(negedge clk_sys);
        chk("pulses after stop", n0, cnt);
        stopN = 3'h7;
        imr = 16'h202a;
        // causes 0..2 stop inputs, 3 plus limit, 4 emergency, 5 alarm
        for (int i = 0; i < 6; i++) begin
            go(0, `AXS_CURVE_CONST, 28'd0);
            stopN = ~(3'h1 << i);
            limN[0] = (i != 3);
            emergency_stop_input = (i != 4);
            almN = (i != 5);
            waitIdle(10);
            chk("plus limit pin", i == 3, motSt[12]);
            {emergency_stop_input, almN, limN, stopN} = '1;
            repeat (4) @(negedge clk_sys);
        end
        p0 = pos;
        cmpU = {1'b1, p0[30:0] + 31'd20};
        lmr = 16'h0001;
        repeat (3) @(negedge clk_sys);
        chk("upper compare 31-bit", 0, geU);
        go(0, `AXS_CURVE_CONST, 28'd0);
        waitIdle(2000);
        chk("soft limit travel", 1, pos - p0 >= 20 && pos - p0 < 24);
        chk("upper compare reached", 1, geU);
        // bit 31 set would make a 32-bit compare say not-below
        cmpL = {1'b1, pos[30:0] + 31'd1};
        repeat (3) @(negedge clk_sys);
        chk("lower compare 31-bit", 1, ltL);
        endSim;
    end
endmodule
`default_nettype wire
